// *** verilog/psr_consts.svh ***
// Constants for the eight-stage parallel-in serial-out shift register
`ifndef PSR_CONSTS_SVH
`define PSR_CONSTS_SVH

// ****************************************************************
// Geometry
// ****************************************************************
`define PSR_STAGES         8
`define PSR_PIN_COUNT      12
`define PSR_SYNC_RESET     12'hFFF

// ****************************************************************
// Register map (byte addresses, one 32-bit word each)
// ****************************************************************
`define PSR_ADR_W          8
`define PSR_OFF_CTRL       8'h00
`define PSR_OFF_STAGE      8'h04
`define PSR_OFF_PINS       8'h08
`define PSR_OFF_COUNT      8'h0C

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define PSR_CTRL_EN_BIT    0
`define PSR_CTRL_RESET     1'h1
`define PSR_CNT_W          8
`define PSR_CNT_ONE        8'h01

`endif

// *** verilog/psr_pkg.sv ***
// Types shared by the shift register design
`default_nettype none

package psr_pkg;

  // Stage vector
  typedef logic [7:0] psr_stage_t;

  // Action taken at a mclk edge, Gray coded along hold-load-shift
  typedef enum logic [1:0] {
    PSR_HOLD  = 2'h0,
    PSR_LOAD  = 2'h1,
    PSR_SHIFT = 2'h3
  } psr_op_e;

endpackage
`default_nettype wire

// *** verilog/psr_pin_sync.sv ***
// Three-flop pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module psr_pin_sync #(
  parameter int          WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] levelOut
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] stab_ff;
  logic [WIDTH-1:0] late_ff;
  logic [WIDTH-1:0] level_ff;

  // ****************************************************************
  // Synchroniser chain; meta_ff feeds stab_ff and nothing else
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= RST_VAL;
      stab_ff <= RST_VAL;
      late_ff <= RST_VAL;
    end else begin
      meta_ff <= pinIn;
      stab_ff <= meta_ff;
      late_ff <= stab_ff;
    end
  end

  // Per bit: a change counts only once second and third flops agree
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      level_ff <= RST_VAL;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stab_ff[i] == late_ff[i]) begin
          level_ff[i] <= late_ff[i];
        end
      end
    end
  end

  assign levelOut = level_ff;

endmodule
`default_nettype wire

// *** verilog/psr_shift_top.sv ***
// Eight-stage parallel-in serial-out shift register with Wishbone status
//
// The placing of the registers and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "psr_consts.svh"

module psr_shift_top (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        async_clear_n,
  input  wire logic        clock_pin,
  input  wire logic        clock_enable_n,
  input  wire logic        load_select_n,
  input  wire logic        serial_in,
  input  wire logic [7:0]  parallel_in,
  output logic             last_stage_out,
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        we_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic [31:0]      dat_o,
  output logic             ack_o
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [11:0]         pinLevel;
  logic                clkLvl;
  logic                inhLvl;
  logic                loadLvl;
  logic                serLvl;
  psr_pkg::psr_stage_t parLvl;
  logic                effLvl;
  logic                effPrev_ff;
  logic                edgeSeen;
  psr_pkg::psr_op_e    op;
  psr_pkg::psr_stage_t stage_ff;
  psr_pkg::psr_stage_t nxt_stage;
  logic                clrMeta_ff;
  logic                clrN_ff;
  logic                clrAsyncN;
  logic                ctrlEn_ff;
  logic [7:0]          loadCnt_ff;
  logic [7:0]          shiftCnt_ff;
  logic                ack_ff;
  logic [31:0]         dat_ff;
  logic [31:0]         nxt_dat;
  logic                busReq;
  logic                busWr;
  logic                cntClr;

  // ****************************************************************
  // Pin sampling
  // ****************************************************************
  // All stage-side pins but the clear share one synchroniser so their latency matches
  psr_pin_sync #(
    .WIDTH   (`PSR_PIN_COUNT),
    .RST_VAL (`PSR_SYNC_RESET)
  ) u_pins (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .pinIn    ({parallel_in, serial_in, load_select_n,
                clock_enable_n, clock_pin}),
    .levelOut (pinLevel)
  );

  assign clkLvl  = pinLevel[0];
  assign inhLvl  = pinLevel[1];
  assign loadLvl = pinLevel[2];
  assign serLvl  = pinLevel[3];
  assign parLvl  = pinLevel[11:4];

  // ****************************************************************
  // Effective clock edge
  // ****************************************************************
  // OR gate treats both pins alike, so they may be swapped
  assign effLvl = clkLvl | inhLvl;

  // Reset high: pins that idle high give no false edge after reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      effPrev_ff <= 1'h1;
    end else begin
      effPrev_ff <= effLvl;
    end
  end

  // Rising edge of the gated level acts as an mclk enable
  assign edgeSeen = effLvl & ~effPrev_ff & ctrlEn_ff;

  // ****************************************************************
  // Clear: asserted at once, released in step with mclk
  // ****************************************************************
  // Release is synchronised so no stage sees a runt recovery
  assign clrAsyncN = rst_n & async_clear_n;

  always_ff @(posedge mclk or negedge clrAsyncN) begin
    if (!clrAsyncN) begin
      clrMeta_ff <= 1'h0;
      clrN_ff    <= 1'h0;
    end else begin
      clrMeta_ff <= 1'h1;
      clrN_ff    <= clrMeta_ff;
    end
  end

  // ****************************************************************
  // Stage register
  // ****************************************************************
  always_comb begin
    if (!edgeSeen) begin
      op = psr_pkg::PSR_HOLD;
    end else if (!loadLvl) begin
      op = psr_pkg::PSR_LOAD;
    end else begin
      op = psr_pkg::PSR_SHIFT;
    end
  end

  always_comb begin
    unique case (op)
      psr_pkg::PSR_HOLD:  nxt_stage = stage_ff;
      psr_pkg::PSR_LOAD:  nxt_stage = parLvl;
      psr_pkg::PSR_SHIFT: nxt_stage = {stage_ff[6:0], serLvl};
      default:            nxt_stage = stage_ff;
    endcase
  end

  // Clear overrides load, shift and inhibit
  always_ff @(posedge mclk or negedge clrAsyncN) begin
    if (!clrAsyncN) begin
      stage_ff <= '0;
    end else if (!clrN_ff) begin
      stage_ff <= '0;
    end else begin
      stage_ff <= nxt_stage;
    end
  end

  // Last stage drives the chain output straight from its flop
  assign last_stage_out = stage_ff[7];

  // ****************************************************************
  // Wishbone slave
  // ****************************************************************
  assign busReq = cyc_i & stb_i & ~ack_ff;
  assign busWr  = busReq & we_i;
  assign cntClr = busWr & (adr_i == `PSR_OFF_COUNT);

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_ff <= 1'h0;
    end else begin
      ack_ff <= busReq;
    end
  end

  // Enable bit gates pin edges; default on so pins work untouched
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlEn_ff <= `PSR_CTRL_RESET;
    end else if (busWr && adr_i == `PSR_OFF_CTRL && sel_i[0]) begin
      ctrlEn_ff <= dat_i[`PSR_CTRL_EN_BIT];
    end
  end

  // Edge counters; an edge in the clearing cycle still counts
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      loadCnt_ff  <= '0;
      shiftCnt_ff <= '0;
    end else begin
      loadCnt_ff  <= (cntClr ? 8'h00 : loadCnt_ff)
                   + ((op == psr_pkg::PSR_LOAD) ? `PSR_CNT_ONE : 8'h00);
      shiftCnt_ff <= (cntClr ? 8'h00 : shiftCnt_ff)
                   + ((op == psr_pkg::PSR_SHIFT) ? `PSR_CNT_ONE : 8'h00);
    end
  end

  // Read mux; unmapped addresses answer with zero
  always_comb begin
    unique case (adr_i)
      `PSR_OFF_CTRL:  nxt_dat = {31'h0, ctrlEn_ff};
      `PSR_OFF_STAGE: nxt_dat = {24'h0, stage_ff};
      `PSR_OFF_PINS:  nxt_dat = {20'h0, pinLevel};
      `PSR_OFF_COUNT: nxt_dat = {16'h0, shiftCnt_ff, loadCnt_ff};
      default:        nxt_dat = 32'h0;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dat_ff <= '0;
    end else if (busReq && !we_i) begin
      dat_ff <= nxt_dat;
    end
  end

  assign ack_o = ack_ff;
  assign dat_o = dat_ff;

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Helper copies so the checks need no part-select of $past
  psr_pkg::psr_stage_t chkPar_ff;
  logic                chkSer_ff;
  psr_pkg::psr_stage_t chkOld_ff;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      chkPar_ff <= '0;
      chkSer_ff <= 1'h0;
      chkOld_ff <= '0;
    end else begin
      chkPar_ff <= parLvl;
      chkSer_ff <= serLvl;
      chkOld_ff <= stage_ff;
    end
  end

  chk_load_parallel:
    assert property (@(posedge mclk) disable iff (!clrAsyncN)
      (op == psr_pkg::PSR_LOAD) && clrN_ff |=> stage_ff == chkPar_ff)
    else $error("Load edge did not copy parallel inputs");

  chk_shift_serial:
    assert property (@(posedge mclk) disable iff (!clrAsyncN)
      (op == psr_pkg::PSR_SHIFT) && clrN_ff |=> stage_ff[0] == chkSer_ff)
    else $error("Shift edge did not capture serial input");

  chk_shift_moves:
    assert property (@(posedge mclk) disable iff (!clrAsyncN)
      (op == psr_pkg::PSR_SHIFT) && clrN_ff
      |=> stage_ff[7:1] == chkOld_ff[6:0])
    else $error("Shift edge did not move stages up by one");

  chk_hold_no_edge:
    assert property (@(posedge mclk) disable iff (!clrAsyncN)
      !edgeSeen && clrN_ff |=> $stable(stage_ff))
    else $error("Stages changed without an effective edge");

  chk_clear_zero:
    assert property (@(posedge mclk) disable iff (!rst_n)
      !async_clear_n |-> stage_ff == 8'h00 && !last_stage_out)
    else $error("Stages not low while clear is active");

  chk_clear_holds:
    assert property (@(posedge mclk) disable iff (!rst_n)
      $fell(clrN_ff) |-> (stage_ff == 8'h00) [*2])
    else $error("Stages left zero too soon after clear");

  chk_inhibit_blocks:
    assert property (@(posedge mclk) disable iff (!rst_n)
      inhLvl && $past(inhLvl) |-> !edgeSeen)
    else $error("Edge taken while inhibit held high");

  chk_gate_swap:
    assert property (@(posedge mclk) disable iff (!rst_n)
      edgeSeen |-> (clkLvl || inhLvl) && !$past(clkLvl) && !$past(inhLvl))
    else $error("Edge taken without a rise of the gated level");

  chk_ack_single:
    assert property (@(posedge mclk) disable iff (!rst_n)
      busReq |=> ack_o ##1 !ack_o)
    else $error("Bus ack not a one-cycle answer");

  chk_count_load:
    assert property (@(posedge mclk) disable iff (!rst_n)
      (op == psr_pkg::PSR_LOAD) && !cntClr
      |=> loadCnt_ff == $past(loadCnt_ff) + 8'h01)
    else $error("Load edge not counted");

  chk_count_shift:
    assert property (@(posedge mclk) disable iff (!rst_n)
      (op == psr_pkg::PSR_SHIFT) && !cntClr
      |=> shiftCnt_ff == $past(shiftCnt_ff) + 8'h01)
    else $error("Shift edge not counted");

  // Software view of the stages must match the flops at request time
  chk_read_stage:
    assert property (@(posedge mclk) disable iff (!rst_n)
      busReq && !we_i && (adr_i == `PSR_OFF_STAGE)
      |=> dat_o == {24'h0, $past(stage_ff)})
    else $error("Stage read returned stale data");

  // Stages leave the cleared state only after the release has settled
  chk_clear_release:
    assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(clrN_ff) |-> stage_ff == 8'h00)
    else $error("Stages moved before clear release settled");

  cov_load:  cover property (@(posedge mclk) op == psr_pkg::PSR_LOAD);
  cov_shift: cover property (@(posedge mclk)
    (op == psr_pkg::PSR_SHIFT) [*2]);
  cov_clear: cover property (@(posedge mclk) !async_clear_n);
  cov_inhib: cover property (@(posedge mclk) inhLvl && $rose(clkLvl));

endmodule
`default_nettype wire

// *** testbench/psr_ctl_model.sv ***
// Controller model that drives the shift register pins
`timescale 1ns/1ps
`default_nettype none

module psr_ctl_model (
  input  wire logic       mclk,
  output var  logic       clockPin,
  output var  logic       clockEnable_n,
  output var  logic       loadSelect_n,
  output var  logic       serialIn,
  output var  logic [7:0] parallelIn
);
  // Idle levels: clock low and stopped, inhibit inactive
  initial begin
    clockPin = 1'b0;
    clockEnable_n = 1'b0;
    loadSelect_n = 1'b1;
    serialIn = 1'b0;
    parallelIn = 8'h00;
  end

  task automatic waitClk(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // One effective edge; data set six cycles before it and held at least twelve after.
  // Swap clocks on the inhibit pin instead. nHold extra clock pulses
  // are given while inhibit is high and must not be taken.
  task automatic pulse(input logic ldN, input logic ser,
                       input logic [7:0] par, input logic swap,
                       input int nHold);
    loadSelect_n <= ldN;
    serialIn <= ser;
    parallelIn <= par;
    waitClk(6);
    if (swap) begin
      clockEnable_n <= 1'b1;
    end else begin
      clockPin <= 1'b1;
    end
    waitClk(6);
    if (nHold > 0) begin
      // Inhibit rises only while the clock pin is high
      clockEnable_n <= 1'b1;
      waitClk(6);
      clockPin <= 1'b0;
      for (int i = 0; i < nHold; i++) begin
        parallelIn <= ~par;
        loadSelect_n <= ~ldN;
        waitClk(6);
        clockPin <= 1'b1;
        waitClk(6);
        clockPin <= 1'b0;
      end
      waitClk(6);
    end
    clockPin <= 1'b0;
    clockEnable_n <= 1'b0;
    waitClk(6);
    // Hold time over: data lines no longer show the old value
    serialIn <= ~ser;
    parallelIn <= ~par;
    waitClk(1);
  endtask
endmodule
`default_nettype wire

// *** testbench/tb_piso_shift_register_8bit.sv ***
// Self-checking bench for the eight-stage shift register
`timescale 1ns/1ps
`default_nettype none
`include "psr_consts.svh"

module tb_piso_shift_register_8bit;
  logic        mclk;
  logic        rst_n;
  logic        asyncClear_n;
  logic        clockPin;
  logic        clockEnable_n;
  logic        loadSelect_n;
  logic        serialIn;
  logic [7:0]  parallelIn;
  logic        lastStage;
  logic [7:0]  adr;
  logic [31:0] datW;
  logic [31:0] datR;
  logic [31:0] rd;
  logic [3:0]  sel;
  logic        we;
  logic        cyc;
  logic        stb;
  logic        ack;
  logic [7:0]  stage;
  logic [7:0]  lfsr;
  int          nErrors;
  int          nTests;
  int          nLoad;
  int          nShift;

  psr_ctl_model ctl (
    .mclk          (mclk),
    .clockPin      (clockPin),
    .clockEnable_n (clockEnable_n),
    .loadSelect_n  (loadSelect_n),
    .serialIn      (serialIn),
    .parallelIn    (parallelIn)
  );

  psr_shift_top uut (
    .mclk(mclk), .rst_n(rst_n), .async_clear_n(asyncClear_n),
    .clock_pin(clockPin), .clock_enable_n(clockEnable_n),
    .load_select_n(loadSelect_n), .serial_in(serialIn),
    .parallel_in(parallelIn), .last_stage_out(lastStage),
    .adr_i(adr), .dat_i(datW), .sel_i(sel), .we_i(we), .cyc_i(cyc),
    .stb_i(stb), .dat_o(datR), .ack_o(ack)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [7:0] nextRand(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction

  // Expected stages after one taken edge
  function automatic logic [7:0] nxtStage(input logic [7:0] st,
      input logic ldN, input logic ser, input logic [7:0] par);
    return ldN ? {st[6:0], ser} : par;
  endfunction

  task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      nErrors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkBit(input logic got, input logic exp);
    chkWord({31'h0, got}, {31'h0, exp});
  endtask

  // Classic Wishbone cycle; only the watchdog ends a lost answer
  task automatic wbXfer(input logic [7:0] a, input logic w,
                        input logic [31:0] d, output logic [31:0] r);
    int k;
    k = 0;
    adr <= a;
    we <= w;
    datW <= d;
    cyc <= 1'b1;
    stb <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (ack !== 1'b1);
    // Registered slave: ack is seen on the second edge of the request
    chkWord(k, 32'h2);
    r = datR;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge mclk);
  endtask

  // One pin operation, then stage readback and output pin check
  task automatic doOp(input logic ldN, input logic ser,
      input logic [7:0] par, input logic swap, input int nHold);
    ctl.pulse(ldN, ser, par, swap, nHold);
    stage = nxtStage(stage, ldN, ser, par);
    if (ldN) nShift++;
    else nLoad++;
    wbXfer(`PSR_OFF_STAGE, 1'b0, 32'h0, rd);
    chkWord(rd, {24'h0, stage});
    chkBit(lastStage, stage[7]);
  endtask

  task automatic final_report;
    if (nErrors == 0 && nTests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // Clock, watchdog and main sequence
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Whole run needs some 1430 cycles; about fourteen times that means a hang
  initial begin
    repeat (20000) @(posedge mclk);
    nErrors++;
    final_report();
  end

  initial begin
    rst_n = 1'b0;
    asyncClear_n = 1'b1;
    {adr, datW, we, cyc, stb} = '0;
    sel = 4'hF;
    {nErrors, nTests, nLoad, nShift} = '0;
    stage = 8'h00;
    lfsr = 8'h4A;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (8) @(posedge mclk);
    wbXfer(`PSR_OFF_CTRL, 1'b0, 32'h0, rd);
    chkWord(rd, 32'h1);
    // Idle pins: only load select high in the filtered pin word
    wbXfer(`PSR_OFF_PINS, 1'b0, 32'h0, rd);
    chkWord(rd, 32'h4);
    wbXfer(8'h10, 1'b1, 32'hFFFFFFFF, rd);
    wbXfer(8'h10, 1'b0, 32'h0, rd);
    chkWord(rd, 32'h0);
    wbXfer(`PSR_OFF_COUNT, 1'b1, 32'h0, rd);
    // Walking one over every parallel bit
    for (int i = 0; i < 8; i++) doOp(1'b0, 1'b0, 8'h01 << i, 1'b0, 0);
    // Random loads and shifts, clock on either pin
    for (int i = 0; i < 40; i++) begin
      lfsr = nextRand(lfsr);
      doOp(lfsr[0], lfsr[1], nextRand(lfsr), lfsr[2], 0);
    end
    doOp(1'b1, 1'b1, 8'h5A, 1'b0, 3);
    // Ring through the serial input: eight shifts restore the pattern
    doOp(1'b0, 1'b0, 8'hC3, 1'b0, 0);
    for (int i = 0; i < 8; i++) doOp(1'b1, lastStage, 8'h00, 1'b0, 0);
    chkWord({24'h0, stage}, 32'hC3);
    wbXfer(`PSR_OFF_COUNT, 1'b0, 32'h0, rd);
    chkWord(rd, {16'h0, nShift[7:0], nLoad[7:0]});
    // Disabled block ignores an edge
    wbXfer(`PSR_OFF_CTRL, 1'b1, 32'h0, rd);
    ctl.pulse(1'b0, 1'b0, 8'hFF, 1'b0, 0);
    wbXfer(`PSR_OFF_STAGE, 1'b0, 32'h0, rd);
    chkWord(rd, 32'hC3);
    wbXfer(`PSR_OFF_CTRL, 1'b1, 32'h1, rd);
    // Clear acts at once, without an edge
    asyncClear_n <= 1'b0;
    #2;
    chkBit(lastStage, 1'b0);
    @(posedge mclk);
    wbXfer(`PSR_OFF_STAGE, 1'b0, 32'h0, rd);
    chkWord(rd, 32'h0);
    stage = 8'h00;
    asyncClear_n <= 1'b1;
    repeat (3) @(posedge mclk);
    doOp(1'b1, 1'b1, 8'h00, 1'b0, 0);
    final_report();
  end
endmodule
`default_nettype wire
